// ### core/spieb_core.v
// spieb_core.v: spi port with overrun/collision detection, interrupt flag, baud generator and mode register.
// assumes a register file port on i_clk_sys; serial pins are asynchronous and synchronised here.
`include "spieb_map.vh"

module spieb_core (
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire i_ce,
    input wire [11:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output wire [7:0] o_reg_rdata,
    input wire i_sck,
    output wire o_sck,
    output wire o_sck_oe,
    input wire i_mosi,
    output wire o_mosi,
    output wire o_mosi_oe,
    input wire i_miso,
    output wire o_miso,
    output wire o_miso_oe,
    input wire i_ss_b,
    output wire o_ss_b,
    output wire o_ss_b_oe,
    output wire o_irq
);

    localparam ST_IDLE = 2'b00;
    localparam ST_MXFER = 2'b01;
    localparam ST_SXFER = 2'b10;

    // decode one register address
    function hit;
        input [11:0] addr;
        input [11:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // length code to bit count, code zero is a full byte
    function [3:0] char_bits;
        input [2:0] code;
        begin
            if (code == 3'b000) begin
                char_bits = `SPIEB_LEN_FULL;
            end else begin
                char_bits = {1'b0, code};
            end
        end
    endfunction

    reg [7:0] ctrl_q;
    reg [7:0] mode_q;
    reg [7:0] brh_q;
    reg [7:0] brl_q;
    reg irq_q;
    reg ovr_q;
    reg col_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] tx_q;
    reg [7:0] tx_d;
    reg [7:0] rx_q;
    reg [7:0] rx_d;
    reg [3:0] bits_q;
    reg [3:0] bits_d;
    reg sck_q;
    reg sck_d;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;

    // two-stage synchronisers for the pins
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg sck_prev_q;
    reg ss_prev_q;

    wire en;
    wire mstr;
    wire irqe;
    wire select_pin_direction;
    wire select_pin_value;
    wire [2:0] len_code;
    wire [15:0] reload;
    wire sck_s;
    wire mosi_s;
    wire miso_s;
    wire ss_b_s;
    wire wr_data;
    wire wr_ctrl;
    wire wr_stat;
    wire wr_mode;
    wire wr_brh;
    wire wr_brl;
    wire busy;
    wire brg_tick;
    wire brg_run;
    wire brg_restart;
    wire start_m;
    wire fault;
    wire slave_sel;
    wire sck_rise;
    wire sck_fall;
    wire ss_rise;
    reg char_done;
    reg set_irq;
    wire [3:0] pins_raw;

    assign en = ctrl_q[`SPIEB_CTRL_EN];
    assign mstr = ctrl_q[`SPIEB_CTRL_MSTR];
    assign irqe = ctrl_q[`SPIEB_CTRL_IRQE];
    assign select_pin_direction = mode_q[`SPIEB_MODE_SELECT_PIN_DIRECTION];
    assign select_pin_value = mode_q[`SPIEB_MODE_SSV];
    assign len_code = mode_q[`SPIEB_MODE_LEN_HI:`SPIEB_MODE_LEN_LO];
    assign reload = {brh_q, brl_q};

    assign pins_raw = {i_ss_b, i_miso, i_mosi, i_sck};
    assign sck_s = sync2_q[0];
    assign mosi_s = sync2_q[1];
    assign miso_s = sync2_q[2];
    assign ss_b_s = sync2_q[3];

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            // pin idle levels: select high, clock low, so no false edge after reset
            sync1_q <= 4'h8;
            sync2_q <= 4'h8;
            sck_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
        end else if (i_ce) begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            sck_prev_q <= sck_s;
            ss_prev_q <= ss_b_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;
    assign ss_rise = ss_b_s & ~ss_prev_q;

    // write strobes
    assign wr_data = i_reg_wr & hit(i_reg_addr, `SPIEB_ADDR_DATA);
    assign wr_ctrl = i_reg_wr & hit(i_reg_addr, `SPIEB_ADDR_CTRL);
    assign wr_stat = i_reg_wr & hit(i_reg_addr, `SPIEB_ADDR_STAT);
    assign wr_mode = i_reg_wr & hit(i_reg_addr, `SPIEB_ADDR_MODE);
    assign wr_brh = i_reg_wr & hit(i_reg_addr, `SPIEB_ADDR_BRH);
    assign wr_brl = i_reg_wr & hit(i_reg_addr, `SPIEB_ADDR_BRL);

    assign busy = (state_q != ST_IDLE);
    assign slave_sel = en & ~mstr & ~ss_b_s;
    assign start_m = wr_data & en & mstr & ~busy & ~fault;
    // select pin driven active from outside while it is an input of an enabled master
    assign fault = en & mstr & ~select_pin_direction & ~ss_b_s;

    // baud generator: serial clock while master busy, free timer while disabled
    assign brg_run = (state_q == ST_MXFER) | ~en;
    assign brg_restart = start_m | wr_brh | wr_brl;

    spieb_brg u_brg (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_run(brg_run),
        .i_restart(brg_restart),
        .i_reload(reload),
        .o_tick(brg_tick)
    );

    // transfer sequencer
    always @* begin
        state_d = state_q;
        tx_d = tx_q;
        rx_d = rx_q;
        bits_d = bits_q;
        sck_d = sck_q;
        char_done = 1'b0;
        case (state_q)
            ST_IDLE: begin
                sck_d = 1'b0;
                if (start_m) begin
                    tx_d = i_reg_wdata;
                    bits_d = char_bits(len_code);
                    state_d = ST_MXFER;
                end else if (wr_data & ~busy) begin
                    tx_d = i_reg_wdata;
                end
                if (slave_sel) begin
                    state_d = ST_SXFER;
                end
            end
            ST_MXFER: begin
                if (!en || !mstr || fault) begin
                    sck_d = 1'b0;
                    state_d = ST_IDLE;
                end else if (brg_tick) begin
                    sck_d = ~sck_q;
                    if (!sck_q) begin
                        rx_d = {rx_q[6:0], miso_s};
                    end else begin
                        tx_d = {tx_q[6:0], 1'b0};
                        bits_d = bits_q - 4'h1;
                        if (bits_q == 4'h1) begin
                            char_done = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end
                end
            end
            ST_SXFER: begin
                if (sck_rise) begin
                    rx_d = {rx_q[6:0], mosi_s};
                end
                if (sck_fall) begin
                    tx_d = {tx_q[6:0], 1'b0};
                end
                if (!en || mstr || ss_rise) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                sck_d = 1'b0;
            end
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            tx_q <= `SPIEB_RST_BYTE;
            rx_q <= `SPIEB_RST_BYTE;
            bits_q <= 4'h0;
            sck_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            bits_q <= bits_d;
            sck_q <= sck_d;
        end
    end

    // interrupt sources
    always @* begin
        set_irq = 1'b0;
        if (irqe) begin
            if (char_done) begin
                set_irq = 1'b1;
            end
            if ((state_q == ST_SXFER) && ss_rise && en && !mstr) begin
                set_irq = 1'b1;
            end
            if (!en && brg_tick) begin
                set_irq = 1'b1;
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            irq_q <= 1'b0;
            ovr_q <= 1'b0;
            col_q <= 1'b0;
        end else if (i_ce) begin
            if (set_irq) begin
                irq_q <= 1'b1;
            end else if (wr_stat && i_reg_wdata[`SPIEB_STAT_IRQ]) begin
                irq_q <= 1'b0;
            end
            if (wr_data && busy) begin
                ovr_q <= 1'b1;
            end else if (wr_stat && i_reg_wdata[`SPIEB_STAT_OVR]) begin
                ovr_q <= 1'b0;
            end
            if (fault) begin
                col_q <= 1'b1;
            end else if (wr_stat && i_reg_wdata[`SPIEB_STAT_COL]) begin
                col_q <= 1'b0;
            end
        end
    end

    // configuration registers
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            ctrl_q <= `SPIEB_RST_CTRL;
            mode_q <= `SPIEB_RST_MODE;
            brh_q <= `SPIEB_RST_BYTE;
            brl_q <= `SPIEB_RST_BYTE;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ctrl_q <= i_reg_wdata & `SPIEB_CTRL_MASK;
            end
            if (wr_mode) begin
                mode_q <= i_reg_wdata & `SPIEB_MODE_MASK;
            end
            if (wr_brh) begin
                brh_q <= i_reg_wdata;
            end
            if (wr_brl) begin
                brl_q <= i_reg_wdata;
            end
        end
    end

    // registered read data, zero for unmapped addresses
    always @* begin
        rdata_d = 8'h00;
        if (hit(i_reg_addr, `SPIEB_ADDR_DATA)) begin
            rdata_d = rx_q;
        end else if (hit(i_reg_addr, `SPIEB_ADDR_CTRL)) begin
            rdata_d = ctrl_q;
        end else if (hit(i_reg_addr, `SPIEB_ADDR_STAT)) begin
            rdata_d[`SPIEB_STAT_IRQ] = irq_q;
            rdata_d[`SPIEB_STAT_OVR] = ovr_q;
            rdata_d[`SPIEB_STAT_COL] = col_q;
            rdata_d[`SPIEB_STAT_BUSY] = busy;
            rdata_d[`SPIEB_STAT_SSIN] = ss_b_s;
        end else if (hit(i_reg_addr, `SPIEB_ADDR_MODE)) begin
            rdata_d = mode_q & `SPIEB_MODE_MASK;
        end else if (hit(i_reg_addr, `SPIEB_ADDR_BRH)) begin
            rdata_d = brh_q;
        end else if (hit(i_reg_addr, `SPIEB_ADDR_BRL)) begin
            rdata_d = brl_q;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rdata_q <= 8'h00;
        end else if (i_ce && i_reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_irq = irq_q;

    // pin drivers
    assign o_sck = sck_q;
    assign o_sck_oe = en & mstr;
    assign o_mosi = tx_q[7];
    assign o_mosi_oe = en & mstr;
    assign o_miso = tx_q[7];
    assign o_miso_oe = slave_sel;
    assign o_ss_b = select_pin_value;
    assign o_ss_b_oe = en & mstr & select_pin_direction;

endmodule // spieb_core

// ### core/spieb_map.vh
// spieb_map.vh: register offsets, field positions and reset values of the spi error/baud/mode block.
// assumes inclusion by bare name from every design file that needs these macros.
`ifndef SPIEB_MAP_VH
`define SPIEB_MAP_VH

// register file addresses
`define SPIEB_ADDR_DATA 12'hf60
`define SPIEB_ADDR_CTRL 12'hf61
`define SPIEB_ADDR_STAT 12'hf62
`define SPIEB_ADDR_MODE 12'hf63
`define SPIEB_ADDR_BRH 12'hf66
`define SPIEB_ADDR_BRL 12'hf67

// control register fields
`define SPIEB_CTRL_IRQE 7
`define SPIEB_CTRL_MSTR 1
`define SPIEB_CTRL_EN 0
`define SPIEB_CTRL_MASK 8'h83

// status register fields
`define SPIEB_STAT_IRQ 7
`define SPIEB_STAT_OVR 6
`define SPIEB_STAT_COL 5
`define SPIEB_STAT_BUSY 1
`define SPIEB_STAT_SSIN 0

// mode register fields
`define SPIEB_MODE_LEN_HI 4
`define SPIEB_MODE_LEN_LO 2
`define SPIEB_MODE_SELECT_PIN_DIRECTION 1
`define SPIEB_MODE_SSV 0
`define SPIEB_MODE_MASK 8'h1f

// reset values
`define SPIEB_RST_CTRL 8'h00
`define SPIEB_RST_MODE 8'h00
`define SPIEB_RST_BRG 16'h0000
`define SPIEB_RST_BYTE 8'h00

// bit count and minimum reload value
`define SPIEB_LEN_FULL 4'h8
`define SPIEB_MIN_RELOAD 16'h0002

`endif

// ### core/spieb_brg.v
// spieb_brg.v: 16-bit down-counting reload generator, one tick per reload period.
// assumes the reload value is stable while running; restart reloads the counter.
`include "spieb_map.vh"

module spieb_brg (
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire i_ce,
    input wire i_run,
    input wire i_restart,
    input wire [15:0] i_reload,
    output wire o_tick
);

    reg [15:0] cnt_q;
    reg [15:0] cnt_d;
    wire at_end;

    // reload of zero gives a full 65536-cycle period
    assign at_end = (cnt_q == 16'h0001);
    assign o_tick = i_run & at_end & ~i_restart;

    always @* begin
        cnt_d = cnt_q;
        if (i_restart) begin
            cnt_d = i_reload;
        end else if (i_run) begin
            if (at_end) begin
                cnt_d = i_reload;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            cnt_q <= `SPIEB_RST_BRG;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
        end
    end

endmodule // spieb_brg

// ### test/spieb_slave_mdl.sv
// spieb_slave_mdl.sv: external spi slave, mode 0, one character per select.
// assumes clock and select come from the master port of the core.
module spieb_slave_mdl (
    input wire logic i_sck,
    input wire logic i_ss_b,
    input wire logic i_mosi,
    input wire logic [7:0] i_byte,
    output logic o_miso,
    output logic [7:0] o_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh = 8'h00;
    logic last = 1'b0;
    always @(negedge i_ss_b) begin
        sh = i_byte;
        o_rx = 8'h00;
    end
    // capture on rise, shift on fall
    always @(posedge i_sck) if (!i_ss_b) o_rx = {o_rx[6:0], i_mosi};
    always @(negedge i_sck) if (!i_ss_b) sh = {sh[6:0], 1'b0};
    // released line shows the inverse of its last level
    always @* begin
        if (!i_ss_b) last = sh[7];
        o_miso = i_ss_b ? ~last : sh[7];
    end
endmodule // spieb_slave_mdl

// ### test/spieb_core_chk.sv
// spieb_core_chk.sv: port-level assertions for spieb_core.
// assumes i_ce held high; bound to every spieb_core instance.
`include "spieb_map.vh"
module spieb_core_chk (
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire [11:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] o_reg_rdata,
    input wire i_ss_b,
    input wire o_sck,
    input wire o_sck_oe,
    input wire o_mosi,
    input wire o_mosi_oe,
    input wire o_miso_oe,
    input wire o_ss_b_oe,
    input wire o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    logic [15:0] reload_q;
    logic sck_q;
    // cycles since the last serial clock edge
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            cnt_q <= 0;
            reload_q <= 16'h0000;
            sck_q <= 1'b0;
        end else begin
            cnt_q <= (o_sck != sck_q) ? 1 : cnt_q + 1;
            sck_q <= o_sck;
            if (i_reg_wr && i_reg_addr == `SPIEB_ADDR_BRH) reload_q[15:8] <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == `SPIEB_ADDR_BRL) reload_q[7:0] <= i_reg_wdata;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    ssoe_master_a: assert property (o_ss_b_oe |-> o_sck_oe)
        else $error("select pin driven outside master mode");
    mosi_oe_a: assert property (o_mosi_oe == o_sck_oe)
        else $error("mosi enable differs from clock enable");
    slave_oe_a: assert property (o_miso_oe |-> !o_sck_oe && !o_ss_b_oe)
        else $error("slave drives master pins");
    rsvd_zero_a: assert property (i_reg_rd && i_reg_addr == `SPIEB_ADDR_MODE |=> o_reg_rdata[7:5] == 3'b000)
        else $error("mode top bits not zero");
    sck_rate_a: assert property (o_sck && !sck_q |-> cnt_q >= reload_q)
        else $error("serial clock half period below reload");
    sck_idle_a: assert property (!o_sck_oe [*2] |-> !o_sck)
        else $error("serial clock high while not master");
    fault_abort_a: assert property ((o_sck_oe && !o_ss_b_oe && !i_ss_b) [*5] |-> !o_sck)
        else $error("collision did not stop the clock");
    mosi_shift_a: assert property (o_sck_oe && $changed(o_mosi) |-> $fell(o_sck) || $past(i_reg_wr))
        else $error("mosi changed off the falling clock");
    cover property ($rose(o_irq));
    cover property (o_sck_oe && $fell(o_sck));
    cover property (o_miso_oe);
endmodule // spieb_core_chk

bind spieb_core spieb_core_chk chk_u (.i_clk_sys, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_ss_b, .o_sck, .o_sck_oe, .o_mosi, .o_mosi_oe, .o_miso_oe, .o_ss_b_oe, .o_irq);

// ### test/spieb_core_tb.sv
// spieb_core_tb.sv: self-checking bench for spieb_core with an external slave model.
// assumes core, map header, checker and slave model compiled first.
`include "spieb_map.vh"
module spieb_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r;} spieb_row_t;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [11:0] i_reg_addr = 12'h000;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic ss_drv_b = 1'b1;
    logic [7:0] slv_byte = 8'h00;
    logic sck_drv = 1'b0;
    logic mosi_drv = 1'b0;
    wire [7:0] o_reg_rdata, mdl_rx;
    wire o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_ss_b, o_ss_b_oe, o_irq, i_miso;
    wire i_ss_b = o_ss_b_oe ? o_ss_b : ss_drv_b;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int sck_rises = 0;
    int t;
    int mark;
    spieb_row_t rows[7] = '{
        '{`SPIEB_ADDR_MODE, 8'hff, 8'h1f},
        '{`SPIEB_ADDR_MODE, 8'h1c, 8'h1c},
        '{`SPIEB_ADDR_CTRL, 8'hff, 8'h83},
        '{`SPIEB_ADDR_BRH, 8'h12, 8'h12},
        '{`SPIEB_ADDR_BRL, 8'h34, 8'h34},
        '{12'hf64, 8'h5a, 8'h00},
        '{`SPIEB_ADDR_MODE, 8'h03, 8'h03}};
    spieb_core dut_u (.i_clk_sys, .i_rst_b, .i_ce(1'b1), .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .i_sck(sck_drv), .o_sck, .o_sck_oe, .i_mosi(mosi_drv), .o_mosi, .o_mosi_oe,
        .i_miso, .o_miso, .o_miso_oe, .i_ss_b, .o_ss_b, .o_ss_b_oe, .o_irq);
    spieb_slave_mdl slv_u (.i_sck(o_sck), .i_ss_b, .i_mosi(o_mosi), .i_byte(slv_byte), .o_miso(i_miso),
        .o_rx(mdl_rx));
    always #12.5 i_clk_sys = ~i_clk_sys;
    always @(posedge o_sck) sck_rises++;
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles >= 6000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask
    task automatic chk_reg(input string what, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
        check(what, e, o_reg_rdata & m);
    endtask
    task automatic wait_irq;
        for (t = 0; t < 300 && o_irq !== 1'b1; t++) @(negedge i_clk_sys);
    endtask
    task automatic xfer(input logic [2:0] code, input logic [7:0] d, input logic [7:0] sb);
        int bits;
        bits = (code == 3'b000) ? 8 : code;
        slv_byte = sb;
        wr_reg(`SPIEB_ADDR_MODE, {3'b000, code, 2'b10});
        sck_rises = 0;
        wr_reg(`SPIEB_ADDR_DATA, d);
        wait_irq();
        check("irq after character", 8'h01, {7'h00, o_irq});
        check("clock rises", 8'(bits), 8'(sck_rises));
        check("slave received", d >> (8 - bits), mdl_rx);
        wr_reg(`SPIEB_ADDR_MODE, {3'b000, code, 2'b11});
        chk_reg("master received", `SPIEB_ADDR_DATA, 8'hff >> (8 - bits), sb >> (8 - bits));
        wr_reg(`SPIEB_ADDR_STAT, 8'h80);
        chk_reg("irq cleared", `SPIEB_ADDR_STAT, 8'h80, 8'h00);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        chk_reg("mode reset", `SPIEB_ADDR_MODE, 8'hff, 8'h00);
        chk_reg("status reset", `SPIEB_ADDR_STAT, 8'he0, 8'h00);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            chk_reg("register readback", rows[i].a, 8'hff, rows[i].r);
        end
        $display("test registers done");
        wr_reg(`SPIEB_ADDR_BRH, 8'h00);
        wr_reg(`SPIEB_ADDR_BRL, 8'h04);
        for (int c = 0; c < 8; c++) xfer(3'(c), 8'h96 ^ 8'(c), 8'h5a ^ 8'(c << 5));
        $display("test master lengths done");
        wr_reg(`SPIEB_ADDR_BRL, 8'h0a);
        wr_reg(`SPIEB_ADDR_MODE, 8'h02);
        wr_reg(`SPIEB_ADDR_DATA, 8'h81);
        wr_reg(`SPIEB_ADDR_DATA, 8'h7e);
        chk_reg("overrun set", `SPIEB_ADDR_STAT, 8'h40, 8'h40);
        wr_reg(`SPIEB_ADDR_STAT, 8'h00);
        chk_reg("overrun kept", `SPIEB_ADDR_STAT, 8'h40, 8'h40);
        wr_reg(`SPIEB_ADDR_STAT, 8'h40);
        chk_reg("overrun cleared", `SPIEB_ADDR_STAT, 8'h40, 8'h00);
        wait_irq();
        wr_reg(`SPIEB_ADDR_MODE, 8'h03);
        wr_reg(`SPIEB_ADDR_MODE, 8'h00);
        chk_reg("collision idle", `SPIEB_ADDR_STAT, 8'h20, 8'h00);
        wr_reg(`SPIEB_ADDR_STAT, 8'h80);
        $display("test overrun done");
        wr_reg(`SPIEB_ADDR_DATA, 8'h3c);
        @(posedge o_sck);
        @(negedge i_clk_sys);
        ss_drv_b = 1'b0;
        repeat (6) @(negedge i_clk_sys);
        chk_reg("collision set", `SPIEB_ADDR_STAT, 8'h22, 8'h20);
        check("clock stopped", 8'h00, {7'h00, o_sck});
        ss_drv_b = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        wr_reg(`SPIEB_ADDR_STAT, 8'h20);
        chk_reg("collision cleared", `SPIEB_ADDR_STAT, 8'h20, 8'h00);
        $display("test collision done");
        wr_reg(`SPIEB_ADDR_CTRL, 8'h81);
        wr_reg(`SPIEB_ADDR_DATA, 8'ha5);
        ss_drv_b = 1'b0;
        repeat (6) @(negedge i_clk_sys);
        check("slave miso enable", 8'h01, {7'h00, o_miso_oe});
        check("slave first bit", 8'h01, {7'h00, o_miso});
        mosi_drv = 1'b1;
        sck_drv = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        sck_drv = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        check("slave second bit", 8'h00, {7'h00, o_miso});
        ss_drv_b = 1'b1;
        wait_irq();
        check("irq on select release", 8'h01, {7'h00, o_irq});
        chk_reg("slave received", `SPIEB_ADDR_DATA, 8'h01, 8'h01);
        $display("test slave done");
        wr_reg(`SPIEB_ADDR_CTRL, 8'h80);
        wr_reg(`SPIEB_ADDR_BRL, 8'h03);
        wr_reg(`SPIEB_ADDR_STAT, 8'h80);
        wait_irq();
        mark = cycles;
        wr_reg(`SPIEB_ADDR_STAT, 8'h80);
        wait_irq();
        check("timer tick spacing", 8'h03, 8'(cycles - mark));
        $display("test timer done");
        i_rst_b = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        check("irq after reset", 8'h00, {7'h00, o_irq});
        chk_reg("control after reset", `SPIEB_ADDR_CTRL, 8'hff, 8'h00);
        chk_reg("baud low after reset", `SPIEB_ADDR_BRL, 8'hff, 8'h00);
        $display("test reset done");
        report_and_stop();
    end
endmodule // spieb_core_tb
